// ### verilog/interrupt_and_tick_watchdog.sv
// Function
// - Interval timer counts system clock divided by 128; halts in STOP mode.
// - Tick request every 2^20 clocks when select is 0, 2^18 when 1.
// - Writing 1 to tick clear resets the interval count; 0 does nothing.
// - Tick clear and watchdog kick bits are write-only, read back 0.
// - Unkicked watchdog resets the device; kick restarts the 2^21 counter except in its final 2^19 stage.
// - Three sources, fixed priority: timer8 0003H, external 0002H, tick 0001H.
// - Highest pending enabled request wins; others stay pending.
// - Global enable set by unmask; cleared by mask, acceptance and reset.
// - Global enable is not readable through the register file.
// - Unmask takes effect only after the following instruction completes.
// - Request flag set by its source, cleared automatically on acceptance.
// - Per-source enable flag; disabled requests wait until enabled.
// - Request flags read/write; write 1 raises, write 0 cancels.
// - Acceptance after current cycle; two-cycle instructions wait second cycle.
// - Acceptance and return each take one instruction cycle.
// - Acceptance stacks five core flags, three levels; buffer, window untouched.
// - External pin flag reads current pin level.
// - Edge select: 0 rising, 1 falling; detected edge sets external request.
// - Leaving STOP resumes timer and watchdog from held counts.
`timescale 1ns/100ps
`include "intc_map.svh"

module interrupt_and_tick_watchdog
  import intc_pkg::*;
#(
  // Division exponents in source ticks (system clock / 128)
  parameter int SLOW_LOG2 = `TICK_SLOW_SRC,
  parameter int FAST_LOG2 = `TICK_FAST_SRC,
  parameter int WD_LOG2   = `WD_STEP_SRC
)(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Instruction sequencer
  input  wire logic       cycle_end,
  input  wire logic       second_cycle_pending,
  input  wire logic       stop_mode,
  input  wire logic       op_unmask,
  input  wire logic       op_mask,
  input  wire logic       op_return,
  // Register file port
  input  wire logic [6:0] rf_addr,
  input  wire logic       rf_write,
  input  wire logic [3:0] rf_wdata,
  output logic [3:0]      rf_rdata,
  // Request sources
  input  wire logic       timer8_event,
  input  wire logic       ext_pin,
  // Core context
  input  wire code_addr_t pc_in,
  input  wire ctx_flags_t flags_in,
  output logic            accept,
  output code_addr_t      vector,
  output logic            return_valid,
  output code_addr_t      return_addr,
  output ctx_flags_t      return_flags,
  // Watchdog
  output logic            watchdog_fault_out_n
);

  localparam logic [13:0] SLOW_MASK = 14'((32'd1 << SLOW_LOG2) - 32'd1);
  localparam logic [13:0] FAST_MASK = 14'((32'd1 << FAST_LOG2) - 32'd1);
  localparam logic [13:0] WD_MASK   = 14'((32'd1 << WD_LOG2) - 32'd1);

  // ==========================================
  // Reset release
  logic [1:0] rst_pipe_reg;
  logic       rst_sync_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= 2'b00;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe_reg[1];

  // ==========================================
  // External pin and context stack
  ctl_state_t st_reg;
  ctl_state_t st_next;
  logic       ext_level;
  logic       ext_edge;
  frame_t     pop_frame;
  logic       accept_now;
  logic       return_now;

  pin_edge_sync u_pin (
    .clock       (clock),
    .rst_sync_n  (rst_sync_n),
    .pin_async   (ext_pin),
    .falling_sel (st_reg.edge_sel),
    .level       (ext_level),
    .edge_pulse  (ext_edge)
  );

  flag_stack u_stack (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .push       (accept_now),
    .push_data  ({pc_in, flags_in}),
    .pop        (return_now),
    .pop_data   (pop_frame)
  );

  // ==========================================
  // Timers, flags and arbitration
  logic       ctrl_wr;
  logic       pre_tick;
  logic       tick_evt;
  logic       wd_step;
  logic       kick_ok;
  logic [2:0] hw_set;
  logic [2:0] pend;
  logic [2:0] win;
  code_addr_t win_vec;
  logic       gie_eff;

  always_comb begin
    ctrl_wr  = rf_write && (rf_addr == `CTRL_ADDR);
    pre_tick = !stop_mode && (st_reg.pre == {`PRESCALE_LOG2{1'b1}});
    tick_evt = pre_tick && ((st_reg.btm & (st_reg.sel ? FAST_MASK : SLOW_MASK))
                            == (st_reg.sel ? FAST_MASK : SLOW_MASK));
    wd_step  = pre_tick && ((st_reg.btm & WD_MASK) == WD_MASK);
    kick_ok  = ctrl_wr && rf_wdata[`CTRL_KICK_BIT] && (st_reg.wd != `WD_LIMIT);
    hw_set   = 3'b000;
    hw_set[`SRC_TIMER8] = timer8_event;
    hw_set[`SRC_EXT]    = ext_edge;
    hw_set[`SRC_TICK]   = tick_evt;
    pend     = st_reg.req & st_reg.en;
    win      = 3'b000;
    win_vec  = `VEC_NONE;
    if (pend[`SRC_TIMER8]) begin
      win[`SRC_TIMER8] = 1'b1;
      win_vec = `VEC_TIMER8;
    end else if (pend[`SRC_EXT]) begin
      win[`SRC_EXT] = 1'b1;
      win_vec = `VEC_EXT;
    end else if (pend[`SRC_TICK]) begin
      win[`SRC_TICK] = 1'b1;
      win_vec = `VEC_TICK;
    end
    // Armed enable counts once the instruction after unmask completes
    gie_eff    = (st_reg.gie == GIE_ON) || (st_reg.gie == GIE_ARMED);
    accept_now = cycle_end && !second_cycle_pending && gie_eff && (|pend)
                 && !op_mask && !op_return;
    return_now = cycle_end && op_return;
  end

  always_comb begin
    st_next           = st_reg;
    st_next.accept    = accept_now;
    st_next.ret_valid = return_now;
    st_next.fault_n   = 1'b1;
    // Interval timer, frozen in STOP with counts held
    if (!stop_mode) begin
      st_next.pre = st_reg.pre + 1'b1;
    end
    if (pre_tick) begin
      st_next.btm = st_reg.btm + 14'd1;
    end
    if (ctrl_wr && rf_wdata[`CTRL_CLEAR_BIT]) begin
      st_next.pre = '0;
      st_next.btm = '0;
    end
    if (ctrl_wr) begin
      st_next.sel = rf_wdata[`CTRL_SELECT_BIT];
    end
    // Watchdog stages; overflow past the limit faults
    if (wd_step) begin
      if (st_reg.wd == `WD_LIMIT) begin
        st_next.wd      = 2'd0;
        st_next.fault_n = 1'b0;
      end else begin
        st_next.wd = st_reg.wd + 2'd1;
      end
    end
    if (kick_ok) begin
      st_next.wd = 2'd0;
    end
    // Request and enable flags; hardware set wins over clears
    if (rf_write && (rf_addr == `REQ_ADDR)) begin
      st_next.req = rf_wdata[2:0];
    end
    if (accept_now) begin
      st_next.req = st_next.req & ~win;
    end
    st_next.req = st_next.req | hw_set;
    if (rf_write && (rf_addr == `EN_ADDR)) begin
      st_next.en = rf_wdata[2:0];
    end
    if (rf_write && (rf_addr == `EXT_ADDR)) begin
      st_next.edge_sel = rf_wdata[`EXT_EDGE_BIT];
    end
    // Global enable
    case (st_reg.gie)
      GIE_OFF: begin
        if (cycle_end && op_unmask) begin
          st_next.gie = GIE_ARMED;
        end
      end
      GIE_ARMED: begin
        if (cycle_end && op_mask) begin
          st_next.gie = GIE_OFF;
        end else if (cycle_end && !second_cycle_pending) begin
          st_next.gie = GIE_ON;
        end
      end
      GIE_ON: begin
        if (cycle_end && op_mask) begin
          st_next.gie = GIE_OFF;
        end
      end
      default: begin
        st_next.gie = GIE_OFF;
      end
    endcase
    if (accept_now) begin
      st_next.gie    = GIE_OFF;
      st_next.vector = win_vec;
    end
    // Read data; global enable state is never visible
    case (rf_addr)
      `CTRL_ADDR: begin
        st_next.rdata = 4'h0;
        st_next.rdata[`CTRL_SELECT_BIT] = st_reg.sel;
      end
      `REQ_ADDR: begin
        st_next.rdata = {1'b0, st_reg.req};
      end
      `EN_ADDR: begin
        st_next.rdata = {1'b0, st_reg.en};
      end
      `EXT_ADDR: begin
        st_next.rdata = 4'h0;
        st_next.rdata[`EXT_EDGE_BIT]  = st_reg.edge_sel;
        st_next.rdata[`EXT_LEVEL_BIT] = ext_level;
      end
      default: begin
        st_next.rdata = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg         <= '0;
      st_reg.gie     <= GIE_OFF;
      st_reg.fault_n <= 1'b1;
      st_reg.req     <= `REQ_RESET;
      st_reg.en      <= `EN_RESET;
      st_reg.edge_sel <= `EDGE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================
  // Outputs
  assign rf_rdata             = st_reg.rdata;
  assign accept               = st_reg.accept;
  assign vector               = st_reg.vector;
  assign return_valid         = st_reg.ret_valid;
  assign return_addr          = pop_frame[`ADDR_W+`FLAGS_W-1:`FLAGS_W];
  assign return_flags         = pop_frame[`FLAGS_W-1:0];
  assign watchdog_fault_out_n = st_reg.fault_n;

  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  a_stop_holds: assert property (
    stop_mode && !ctrl_wr |=> $stable(st_reg.pre) && $stable(st_reg.btm))
    else $error("interval timer moved during stop");

  a_tick_period: assert property (
    tick_evt |-> pre_tick && ((st_reg.btm & (st_reg.sel ? FAST_MASK : SLOW_MASK))
                              == (st_reg.sel ? FAST_MASK : SLOW_MASK)) ##1 st_reg.req[`SRC_TICK])
    else $error("tick request not raised at period end");

  a_clear_zero: assert property (
    ctrl_wr && rf_wdata[`CTRL_CLEAR_BIT] |=> st_reg.btm == 14'd0 && st_reg.pre == '0)
    else $error("tick clear did not reset count");

  a_ctrl_readback: assert property (
    rf_addr == `CTRL_ADDR |=> rf_rdata[`CTRL_KICK_BIT] == 1'b0
                              && rf_rdata[`CTRL_CLEAR_BIT] == 1'b0 && rf_rdata[0] == 1'b0)
    else $error("write-only control bits read nonzero");

  a_wd_kick: assert property (
    kick_ok |=> st_reg.wd == 2'd0 && watchdog_fault_out_n)
    else $error("watchdog kick not honoured");

  a_wd_fault: assert property (
    !watchdog_fault_out_n |-> $past(st_reg.wd) == `WD_LIMIT && $past(wd_step) ##1 watchdog_fault_out_n)
    else $error("watchdog fault without expiry");

  a_vector_load: assert property (
    accept_now |=> accept && vector == $past(win_vec) && vector != `VEC_NONE)
    else $error("vector not loaded on acceptance");

  a_priority: assert property (
    accept_now && !win[`SRC_TIMER8] |-> !pend[`SRC_TIMER8])
    else $error("lower priority accepted over timer8");

  a_accept_masks: assert property (
    accept_now |=> st_reg.gie == GIE_OFF ##0 !accept_now)
    else $error("global enable not cleared on acceptance");

  a_unmask_delay: assert property (
    st_reg.gie == GIE_OFF && cycle_end && op_unmask |-> !accept_now ##1 st_reg.gie == GIE_ARMED)
    else $error("acceptance at unmask boundary");

  a_req_clear: assert property (
    accept_now && !(|(win & hw_set)) |=> !(|(st_reg.req & $past(win))))
    else $error("winning request not cleared");

  a_enable_gate: assert property (
    accept_now |-> |(win & st_reg.en))
    else $error("disabled source accepted");

  a_two_cycle: assert property (
    second_cycle_pending |-> !accept_now)
    else $error("acceptance inside two-cycle instruction");

endmodule

// ### verilog/intc_map.svh
`ifndef INTC_MAP_SVH
`define INTC_MAP_SVH

// ==========================================
// Register file addresses
`define CTRL_ADDR        7'h03
`define REQ_ADDR         7'h3D
`define EN_ADDR          7'h3E
`define EXT_ADDR         7'h3F

// ==========================================
// Field positions
`define CTRL_CLEAR_BIT   1
`define CTRL_SELECT_BIT  2
`define CTRL_KICK_BIT    3
`define EXT_EDGE_BIT     0
`define EXT_LEVEL_BIT    1
`define SRC_TICK         0
`define SRC_EXT          1
`define SRC_TIMER8       2

// ==========================================
// Reset values
`define CTRL_RESET       4'h0
`define REQ_RESET        3'h0
`define EN_RESET         3'h0
`define EDGE_RESET       1'b0

// ==========================================
// Vector addresses
`define VEC_TIMER8       13'h0003
`define VEC_EXT          13'h0002
`define VEC_TICK         13'h0001
`define VEC_NONE         13'h0000

// ==========================================
// Timing (log2 of system clock division)
`define PRESCALE_LOG2    7
`define TICK_SLOW_LOG2   20
`define TICK_FAST_LOG2   18
`define WD_STEP_LOG2     19
`define TICK_SLOW_SRC    (`TICK_SLOW_LOG2 - `PRESCALE_LOG2)
`define TICK_FAST_SRC    (`TICK_FAST_LOG2 - `PRESCALE_LOG2)
`define WD_STEP_SRC      (`WD_STEP_LOG2 - `PRESCALE_LOG2)
`define WD_LIMIT         2'h3

// ==========================================
// Stack geometry
`define STACK_DEPTH      3
`define ADDR_W           13
`define FLAGS_W          5

`endif

// ### verilog/intc_pkg.sv
`include "intc_map.svh"

package intc_pkg;

  typedef enum logic [1:0] {
    GIE_OFF,
    GIE_ARMED,
    GIE_ON
  } gie_state_t;

  typedef logic [`ADDR_W-1:0]  code_addr_t;
  typedef logic [`FLAGS_W-1:0] ctx_flags_t;
  typedef logic [`ADDR_W+`FLAGS_W-1:0] frame_t;

  typedef struct packed {
    logic [`PRESCALE_LOG2-1:0] pre;
    logic [13:0]               btm;
    logic [1:0]                wd;
    logic                      sel;
    logic [2:0]                req;
    logic [2:0]                en;
    logic                      edge_sel;
    gie_state_t                gie;
    logic                      accept;
    code_addr_t                vector;
    logic                      ret_valid;
    logic                      fault_n;
    logic [3:0]                rdata;
  } ctl_state_t;

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_t;

  typedef struct packed {
    logic [`STACK_DEPTH-1:0][`ADDR_W+`FLAGS_W-1:0] mem;
    logic [1:0]                                    ptr;
    logic [`ADDR_W+`FLAGS_W-1:0]                   rdata;
  } stack_state_t;

endpackage

// ### verilog/pin_edge_sync.sv
`timescale 1ns/100ps

module pin_edge_sync
  import intc_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_sync_n,
  // Pin side
  input  wire logic pin_async,
  input  wire logic falling_sel,
  // Synchronised results
  output logic      level,
  output logic      edge_pulse
);

  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.meta = pin_async;
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level      = st_reg.sync;
  assign edge_pulse = falling_sel ? (st_reg.prev & ~st_reg.sync)
                                  : (~st_reg.prev & st_reg.sync);

endmodule

// ### verilog/flag_stack.sv
`timescale 1ns/100ps

module flag_stack
  import intc_pkg::*;
(
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst_sync_n,
  // Push and pop
  input  wire logic   push,
  input  wire frame_t push_data,
  input  wire logic   pop,
  output frame_t      pop_data
);

  stack_state_t st_reg;
  stack_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      // Beyond three levels the top entry is overwritten
      if (st_reg.ptr == 2'd3) begin
        st_next.mem[2] = push_data;
      end else begin
        st_next.mem[st_reg.ptr] = push_data;
        st_next.ptr = st_reg.ptr + 2'd1;
      end
    end else if (pop) begin
      if (st_reg.ptr == 2'd0) begin
        st_next.rdata = '0;
      end else begin
        st_next.rdata = st_reg.mem[st_reg.ptr - 2'd1];
        st_next.ptr   = st_reg.ptr - 2'd1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pop_data = st_reg.rdata;

endmodule

// ### tb/core_seq_model.sv
`timescale 1ns/100ps

module core_seq_model
  import intc_pkg::*;
#(
  parameter int CYC = 4
)(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Bench commands
  input  wire logic [1:0] op_sel,
  input  wire logic       two_cycle,
  // Controller answers
  input  wire logic       accept,
  input  wire code_addr_t vector,
  input  wire logic       return_valid,
  input  wire code_addr_t return_addr,
  // Sequencer outputs
  output logic            cycle_end,
  output logic            second_cycle_pending,
  output logic            op_unmask,
  output logic            op_mask,
  output logic            op_return,
  output code_addr_t      pc_in,
  output ctx_flags_t      flags_in
);
  logic [7:0] div_reg;
  code_addr_t pc_reg;

  // ==========================================
  // Instruction pacing and program counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 8'h00;
      pc_reg  <= 13'h0100;
    end else begin
      div_reg <= (div_reg == 8'(CYC - 1)) ? 8'h00 : div_reg + 8'h01;
      if (accept) begin
        pc_reg <= vector;
      end else if (return_valid) begin
        pc_reg <= return_addr;
      end
    end
  end

  assign cycle_end            = (div_reg == 8'(CYC - 1));
  assign second_cycle_pending = cycle_end & two_cycle;
  assign op_unmask            = cycle_end & (op_sel == 2'h1);
  assign op_mask              = cycle_end & (op_sel == 2'h2);
  assign op_return            = cycle_end & (op_sel == 2'h3);
  assign pc_in                = pc_reg;
  // Buffer and window context stays with handler software
  assign flags_in             = pc_reg[4:0] ^ 5'h15;
endmodule

// ### tb/interrupt_and_tick_watchdog_tb.sv
`timescale 1ns/100ps
`include "intc_map.svh"

module interrupt_and_tick_watchdog_tb
  import intc_pkg::*;
;
  localparam int CYC = 4;
  logic       clock, rst_n, stop_mode, two_cycle, timer8_event, ext_pin;
  logic       cycle_end, second_cycle_pending, op_unmask, op_mask, op_return;
  logic       rf_write, accept, return_valid, watchdog_fault_out_n;
  logic [1:0] op_sel;
  logic [6:0] rf_addr;
  logic [3:0] rf_wdata, rf_rdata, d;
  code_addr_t pc_in, vector, return_addr;
  ctx_flags_t flags_in, return_flags;
  code_addr_t spc [3];
  ctx_flags_t sfl [3];
  logic [6:0] addrs [5] = '{`CTRL_ADDR, `REQ_ADDR, `EN_ADDR, `EXT_ADDR, 7'h10};
  int         n, e, failures, n_checks;
  int         faults = 0;

  interrupt_and_tick_watchdog #(.SLOW_LOG2(3), .FAST_LOG2(2), .WD_LOG2(3)) DUT (
    .clock(clock), .rst_n(rst_n), .cycle_end(cycle_end),
    .second_cycle_pending(second_cycle_pending), .stop_mode(stop_mode),
    .op_unmask(op_unmask), .op_mask(op_mask), .op_return(op_return),
    .rf_addr(rf_addr), .rf_write(rf_write), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata),
    .timer8_event(timer8_event), .ext_pin(ext_pin), .pc_in(pc_in), .flags_in(flags_in),
    .accept(accept), .vector(vector), .return_valid(return_valid),
    .return_addr(return_addr), .return_flags(return_flags),
    .watchdog_fault_out_n(watchdog_fault_out_n));

  core_seq_model #(.CYC(CYC)) M (
    .clock(clock), .rst_n(rst_n), .op_sel(op_sel), .two_cycle(two_cycle),
    .accept(accept), .vector(vector), .return_valid(return_valid),
    .return_addr(return_addr), .cycle_end(cycle_end),
    .second_cycle_pending(second_cycle_pending), .op_unmask(op_unmask),
    .op_mask(op_mask), .op_return(op_return), .pc_in(pc_in), .flags_in(flags_in));

  // ==========================================
  // Clock, fault monitor, watchdog
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(negedge clock) begin
    if (watchdog_fault_out_n === 1'b0) begin
      faults++;
    end
  end

  initial begin
    repeat (30000) @(posedge clock);
    failures++;
    complete_run();
  end

  // ==========================================
  // Tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rf_wr(input logic [6:0] a, input logic [3:0] v);
    @(negedge clock);
    rf_addr = a;
    rf_wdata = v;
    rf_write = 1'b1;
    @(negedge clock);
    rf_write = 1'b0;
  endtask

  task automatic rf_rd(input logic [6:0] a);
    @(negedge clock);
    rf_addr = a;
    @(negedge clock);
    d = rf_rdata;
  endtask

  task automatic issue(input logic [1:0] op);
    do @(negedge clock); while (cycle_end !== 1'b1);
    op_sel = op;
    @(negedge clock);
    op_sel = 2'h0;
  endtask

  task automatic wait_accept(input int lim);
    n = 0;
    while (accept !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic tick_time(input logic sel, input int hold);
    rf_wr(`CTRL_ADDR, {1'b1, sel, 2'b10});
    rf_wr(`REQ_ADDR, 4'h0);
    if (hold > 0) begin
      stop_mode = 1'b1;
      repeat (hold) @(negedge clock);
      stop_mode = 1'b0;
    end
    n = 2 + hold;
    d = 4'h0;
    while (d[0] !== 1'b1 && n < 2000) begin
      rf_rd(`REQ_ADDR);
      n += 2;
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // Test sequence
  initial begin
    rst_n = 1'b0;
    {stop_mode, two_cycle, timer8_event, ext_pin, rf_write} = 5'h00;
    op_sel = 2'h0;
    rf_addr = 7'h00;
    rf_wdata = 4'h0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    foreach (addrs[i]) begin
      rf_rd(addrs[i]);
      check("reset value", 16'(d), 16'h0000);
    end
    rf_wr(`CTRL_ADDR, 4'hF);
    rf_rd(`CTRL_ADDR);
    check("ctrl readback", 16'(d), 16'h0004);
    // Timer8 and external sources raise their own flags
    @(negedge clock);
    timer8_event = 1'b1;
    @(negedge clock);
    timer8_event = 1'b0;
    ext_pin = 1'b1;
    repeat (4) @(negedge clock);
    rf_rd(`REQ_ADDR);
    check("hardware requests", 16'(d), 16'h0006);
    rf_wr(`REQ_ADDR, 4'h7);
    rf_rd(`EXT_ADDR);
    check("pin level", 16'(d), 16'h0002);
    rf_rd(`REQ_ADDR);
    check("requests set", 16'(d), 16'h0007);
    rf_wr(`EN_ADDR, 4'h7);
    for (int k = 0; k < 3; k++) begin
      issue(2'h1);
      wait_accept(3 * CYC);
      check("unmask delay", 16'(n > 1), 16'h0001);
      check("vector", 16'(vector), 16'(3 - k));
      spc[k] = pc_in;
      sfl[k] = flags_in;
      rf_rd(`REQ_ADDR);
      check("request cleared", 16'(d), 16'(7 >> (k + 1)));
      wait_accept(3 * CYC);
      check("enable cleared", 16'(n), 16'(3 * CYC));
    end
    rf_wr(`EXT_ADDR, 4'h1);
    ext_pin = 1'b0;
    repeat (4) @(negedge clock);
    rf_rd(`REQ_ADDR);
    check("falling edge", 16'(d), 16'h0002);
    rf_wr(`REQ_ADDR, 4'h0);
    rf_rd(`REQ_ADDR);
    check("cancel", 16'(d), 16'h0000);
    for (int k = 2; k >= 0; k--) begin
      issue(2'h3);
      check("return valid", 16'(return_valid), 16'h0001);
      check("return addr", 16'(return_addr), 16'(spc[k]));
      check("return flags", 16'(return_flags), 16'(sfl[k]));
    end
    // Mask, then a two-cycle instruction
    @(negedge clock);
    timer8_event = 1'b1;
    @(negedge clock);
    timer8_event = 1'b0;
    issue(2'h1);
    issue(2'h2);
    wait_accept(4 * CYC);
    check("mask blocks", 16'(n), 16'(4 * CYC));
    issue(2'h1);
    two_cycle = 1'b1;
    do @(negedge clock); while (cycle_end !== 1'b1);
    @(negedge clock);
    check("second cycle defers", 16'(accept), 16'h0000);
    two_cycle = 1'b0;
    wait_accept(2 * CYC);
    check("deferred vector", 16'(vector), 16'h0003);
    // Interval periods, clear and stop
    rf_wr(`EN_ADDR, 4'h0);
    for (int k = 0; k < 3; k++) begin
      e = ((k == 0) ? 1024 : 512) + ((k == 2) ? 300 : 0);
      tick_time(k != 0, (k == 2) ? 300 : 0);
      check("tick period", 16'(n >= e - 2 && n <= e + 6), 16'h0001);
    end
    // Watchdog: kicks in time, then a late one
    rf_wr(`CTRL_ADDR, 4'hA);
    repeat (2500) @(negedge clock);
    rf_wr(`CTRL_ADDR, 4'hA);
    repeat (3300) @(negedge clock);
    rf_wr(`CTRL_ADDR, 4'h8);
    check("no fault while kicked", 16'(faults), 16'h0000);
    n = 3302;
    while (faults == 0 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    check("fault time", 16'(n >= 4080 && n <= 4112), 16'h0001);
    repeat (4) @(negedge clock);
    check("fault pulse", 16'(faults), 16'h0001);
    complete_run();
  end
endmodule
